// ==== rtl/ead_pkg.sv ====
// Package of constants for the external access decoder
package ead_pkg;
  // External register offsets
  localparam logic [2:0] EAD_OFS_DATA_LOW = 3'h0;
  localparam logic [2:0] EAD_OFS_DATA_MID = 3'h1;
  localparam logic [2:0] EAD_OFS_DATA_TOP = 3'h2;
  localparam logic [2:0] EAD_OFS_SLEEP = 3'h3;
  localparam logic [2:0] EAD_OFS_PIN_SYNC = 3'h4;
  localparam logic [2:0] EAD_OFS_SOFT_SYNC = 3'h5;
  localparam logic [2:0] EAD_OFS_POINTER = 3'h6;
  localparam logic [2:0] EAD_OFS_ACCESS = 3'h7;
  // Access mode control fields
  localparam int EAD_ACC_AUTOINC_BIT = 7;
  localparam int EAD_ACC_BCAST_BIT = 6;
  localparam int EAD_ACC_INSTR_LSB = 2;
  localparam int EAD_ACC_CHAN_LSB = 0;
  // Sleep register page select bit
  localparam int EAD_SLEEP_PAGE_BIT = 5;
  // Control byte field positions
  localparam int EAD_SOFT_START_BIT = 4;
  localparam int EAD_SOFT_HOP_BIT = 5;
  localparam int EAD_SOFT_TEST_LSB = 6;
  localparam int EAD_PIN_START_BIT = 4;
  localparam int EAD_PIN_HOP_BIT = 5;
  localparam int EAD_PIN_FIRST_BIT = 6;
  // Stored bits of the write-only bytes; pulse and reserved bits drop
  localparam logic [7:0] EAD_KEEP_SLEEP = 8'h2f;
  localparam logic [7:0] EAD_KEEP_PIN = 8'h7f;
  localparam logic [7:0] EAD_KEEP_SOFT = 8'hcf;
  // Broadcast instruction codes
  localparam logic [3:0] EAD_INS_ALL = 4'h0;
  localparam logic [3:0] EAD_INS_CH012 = 4'h1;
  localparam logic [3:0] EAD_INS_CH123 = 4'h2;
  localparam logic [3:0] EAD_INS_ANY_CHIP = 4'h4;
  localparam logic [3:0] EAD_INS_LSB0 = 4'h8;
  localparam logic [3:0] EAD_INS_LSB1 = 4'h9;
  localparam logic [1:0] EAD_INS_TWO_LSB_TAG = 2'h3;
  // Channel enable masks
  localparam logic [3:0] EAD_MASK_ALL = 4'hf;
  localparam logic [3:0] EAD_MASK_CH012 = 4'h7;
  localparam logic [3:0] EAD_MASK_CH123 = 4'he;
  // Reset values
  localparam logic [7:0] EAD_RST_BYTE = 8'h00;
  localparam logic [3:0] EAD_RST_NIBBLE = 4'h0;
endpackage : ead_pkg

// ==== rtl/ead_chan_decode.sv ====
// Channel select decoder from access mode and straps
`timescale 1ns/1ps
`default_nettype none
module ead_chan_decode (
  input wire logic [7:0] access_mode,
  input wire logic [3:0] device_select_straps,
  output logic [3:0] chan_en
);
  logic bcast;
  logic [3:0] instr;
  logic [1:0] chan_sel;
  logic [3:0] one_chan;
  logic lsb_hit;
  logic two_hit;
  assign bcast = access_mode[ead_pkg::EAD_ACC_BCAST_BIT];
  assign instr = access_mode[ead_pkg::EAD_ACC_INSTR_LSB +: 4];
  assign chan_sel = access_mode[ead_pkg::EAD_ACC_CHAN_LSB +: 2];
  // Single channel by the low access mode bits
  assign one_chan = 4'h1 << chan_sel;
  assign lsb_hit = (instr == ead_pkg::EAD_INS_LSB0 && !device_select_straps[0])
    || (instr == ead_pkg::EAD_INS_LSB1 && device_select_straps[0]);
  assign two_hit = (instr[3:2] == ead_pkg::EAD_INS_TWO_LSB_TAG)
    && (instr[1:0] == device_select_straps[1:0]);
  // Multi-channel codes ignore the channel bits
  always_comb begin
    if (!bcast) begin
      chan_en = (instr == device_select_straps) ? one_chan : 4'h0;
    end else begin
      case (instr)
        ead_pkg::EAD_INS_ALL: chan_en = ead_pkg::EAD_MASK_ALL;
        ead_pkg::EAD_INS_CH012: chan_en = ead_pkg::EAD_MASK_CH012;
        ead_pkg::EAD_INS_CH123: chan_en = ead_pkg::EAD_MASK_CH123;
        ead_pkg::EAD_INS_ANY_CHIP: chan_en = one_chan;
        default: chan_en = (lsb_hit || two_hit) ? one_chan : 4'h0;
      endcase
    end
  end
endmodule : ead_chan_decode
`default_nettype wire

// ==== rtl/ead_wo_reg.sv ====
// Write-only control byte with reserved bits forced low
`timescale 1ns/1ps
`default_nettype none
module ead_wo_reg #(
  parameter logic [7:0] KEEP_MASK = 8'hff
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] value
);
  logic [7:0] value_r;
  // Reserved positions never hold a one
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      value_r <= ead_pkg::EAD_RST_BYTE;
    end else if (wr_en) begin
      value_r <= wr_data & KEEP_MASK;
    end
  end
  assign value = value_r;
endmodule : ead_wo_reg
`default_nettype wire

// ==== rtl/ead_external_access_decoder.sv ====
// External access decoder: eight-register host map to internal pages
//
// Summary of operation
// - Eight registers, addresses zero to seven
// - Same map for serial and parallel
// - Auto-increment pointer after low data access
// - Non-broadcast: instruction must match straps
// - Broadcast code 0000 hits all channels
// - Codes 0001/0010 hit channel triples
// - Code 0100: all chips, addressed channel
// - Codes 1000/1001 match strap bit zero
// - Codes 11xx match two low strap bits
// - Pointer reads zero while broadcast set
// - Low access bits pick single channel
// - Sync and sleep registers are write-only
// - Data bytes form one 20-bit word
// - Sleep bit five selects output page
// - Low data write/read launches internal access
// - Pointer addresses output map when selected
// - Top data register keeps four bits
`timescale 1ns/1ps
`default_nettype none
module ead_external_access_decoder (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic host_cs,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [2:0] host_addr,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  output logic host_rdata_oe,
  input wire logic [3:0] device_select_straps,
  output logic [3:0] int_chan_en,
  output logic int_out_page,
  output logic [7:0] int_addr,
  output logic [19:0] int_wdata,
  output logic int_wr,
  output logic int_rd,
  input wire logic [19:0] int_rdata,
  output logic [3:0] sleep_chan,
  output logic [3:0] pin_sync_en,
  output logic pin_start_en,
  output logic pin_hop_en,
  output logic pin_first_only,
  output logic [3:0] soft_sync_chan,
  output logic soft_start_pulse,
  output logic soft_hop_pulse,
  output logic selftest_input_route,
  output logic noise_source_select
);
  ////////////////////////////////////////////////////////////////////////
  // Host-side decode, one cycle per access on either port
  logic wr_hit;
  logic rd_hit;
  logic [7:0] addr_dec;
  logic [3:0] chan_en;
  logic selected;
  logic bcast;
  logic autoinc;
  logic launch_wr;
  logic launch_rd;
  logic bump;
  // Both serial and parallel front ends feed this one strobe set
  assign wr_hit = host_cs & host_wr;
  assign rd_hit = host_cs & host_rd & ~host_wr;
  assign addr_dec = 8'h01 << host_addr;

  // Per-register write strobes, one named wire each
  logic wr_access;
  logic wr_pointer;
  logic wr_low;
  logic wr_mid;
  logic wr_top;
  logic wr_sleep;
  logic wr_pin;
  assign wr_access = wr_hit & addr_dec[ead_pkg::EAD_OFS_ACCESS];
  assign wr_pointer = wr_hit & addr_dec[ead_pkg::EAD_OFS_POINTER];
  assign wr_low = wr_hit & addr_dec[ead_pkg::EAD_OFS_DATA_LOW];
  assign wr_mid = wr_hit & addr_dec[ead_pkg::EAD_OFS_DATA_MID];
  assign wr_top = wr_hit & addr_dec[ead_pkg::EAD_OFS_DATA_TOP];
  assign wr_sleep = wr_hit & addr_dec[ead_pkg::EAD_OFS_SLEEP];
  assign wr_pin = wr_hit & addr_dec[ead_pkg::EAD_OFS_PIN_SYNC];

  ////////////////////////////////////////////////////////////////////////
  // Access mode and pointer registers
  logic [7:0] access_mode_control_r;
  logic [7:0] access_mode_control_nxt;
  logic [7:0] internal_address_pointer_r;
  logic [7:0] internal_address_pointer_nxt;
  assign bcast = access_mode_control_r[ead_pkg::EAD_ACC_BCAST_BIT];
  assign autoinc = access_mode_control_r[ead_pkg::EAD_ACC_AUTOINC_BIT];
  logic [7:0] pointer_step;
  logic [7:0] pointer_kept;
  assign access_mode_control_nxt = wr_access ? host_wdata : access_mode_control_r;
  // Increment wraps at the top of the page; the carry is dropped on purpose
  assign pointer_step = 8'(internal_address_pointer_r + 8'h01);
  // Pointer write wins over increment in the same cycle
  assign bump = autoinc & (launch_wr | launch_rd);
  assign pointer_kept = bump ? pointer_step : internal_address_pointer_r;
  assign internal_address_pointer_nxt = wr_pointer ? host_wdata : pointer_kept;

  // Access mode register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      access_mode_control_r <= ead_pkg::EAD_RST_BYTE;
    end else begin
      access_mode_control_r <= access_mode_control_nxt;
    end
  end

  // Pointer register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      internal_address_pointer_r <= ead_pkg::EAD_RST_BYTE;
    end else begin
      internal_address_pointer_r <= internal_address_pointer_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Channel select decode
  ead_chan_decode u_decode (
    .access_mode(access_mode_control_r),
    .device_select_straps(device_select_straps),
    .chan_en(chan_en)
  );
  // Strap mismatch blocks the internal launch and, except for the access mode register, the read drive; the host write still loads the low byte
  assign selected = |chan_en;
  assign launch_wr = wr_hit & addr_dec[ead_pkg::EAD_OFS_DATA_LOW] & selected;
  assign launch_rd = rd_hit & addr_dec[ead_pkg::EAD_OFS_DATA_LOW] & selected;

  ////////////////////////////////////////////////////////////////////////
  // Data holding registers for the 20-bit word
  logic [7:0] data_low_byte_r;
  logic [7:0] data_low_byte_nxt;
  logic [7:0] data_mid_byte_r;
  logic [7:0] data_mid_byte_nxt;
  logic [3:0] data_top_nibble_r;
  logic [3:0] data_top_nibble_nxt;
  logic [7:0] low_kept;
  logic [7:0] mid_kept;
  logic [3:0] top_kept;
  // Internal read lands in all three bytes; low byte bypassed to host
  assign low_kept = launch_rd ? int_rdata[7:0] : data_low_byte_r;
  assign mid_kept = launch_rd ? int_rdata[15:8] : data_mid_byte_r;
  assign top_kept = launch_rd ? int_rdata[19:16] : data_top_nibble_r;
  // Host writes win; only one register is addressed per cycle
  assign data_low_byte_nxt = wr_low ? host_wdata : low_kept;
  assign data_mid_byte_nxt = wr_mid ? host_wdata : mid_kept;
  // Upper four bits of a top-byte write are dropped
  assign data_top_nibble_nxt = wr_top ? host_wdata[3:0] : top_kept;

  // Low data byte, also the low part of the outgoing word
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      data_low_byte_r <= ead_pkg::EAD_RST_BYTE;
    end else begin
      data_low_byte_r <= data_low_byte_nxt;
    end
  end

  // Middle data byte
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      data_mid_byte_r <= ead_pkg::EAD_RST_BYTE;
    end else begin
      data_mid_byte_r <= data_mid_byte_nxt;
    end
  end

  // Top data nibble
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      data_top_nibble_r <= ead_pkg::EAD_RST_NIBBLE;
    end else begin
      data_top_nibble_r <= data_top_nibble_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write-only control registers, reserved bits masked off
  logic [7:0] sleep_val;
  logic [7:0] pin_val;
  logic [7:0] soft_val;
  logic soft_wr;
  ead_wo_reg #(.KEEP_MASK(ead_pkg::EAD_KEEP_SLEEP)) u_sleep (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .wr_en(wr_sleep),
    .wr_data(host_wdata),
    .value(sleep_val)
  );
  ead_wo_reg #(.KEEP_MASK(ead_pkg::EAD_KEEP_PIN)) u_pin_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .wr_en(wr_pin),
    .wr_data(host_wdata),
    .value(pin_val)
  );
  ead_wo_reg #(.KEEP_MASK(ead_pkg::EAD_KEEP_SOFT)) u_soft_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .wr_en(soft_wr),
    .wr_data(host_wdata),
    .value(soft_val)
  );
  assign soft_wr = wr_hit & addr_dec[ead_pkg::EAD_OFS_SOFT_SYNC];

  ////////////////////////////////////////////////////////////////////////
  // Outputs toward the internal pages and control fields
  logic [3:0] int_chan_en_r;
  logic int_out_page_r;
  logic [7:0] int_addr_r;
  logic int_wr_r;
  logic int_rd_r;
  logic [3:0] sleep_chan_r;
  logic [6:0] pin_r;
  logic [3:0] soft_chan_r;
  logic soft_start_r;
  logic soft_hop_r;
  logic [1:0] test_r;
  // Launch strobes with the channels and address that go with them
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      int_chan_en_r <= 4'h0;
      int_addr_r <= ead_pkg::EAD_RST_BYTE;
      int_wr_r <= 1'b0;
      int_rd_r <= 1'b0;
    end else begin
      int_chan_en_r <= chan_en;
      int_addr_r <= internal_address_pointer_r;
      int_wr_r <= launch_wr;
      int_rd_r <= launch_rd;
    end
  end

  // Levels lag a write by two edges, pulses by one; hosts must allow for it
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      int_out_page_r <= 1'b0;
      sleep_chan_r <= 4'h0;
    end else begin
      int_out_page_r <= sleep_val[ead_pkg::EAD_SLEEP_PAGE_BIT];
      sleep_chan_r <= sleep_val[3:0];
    end
  end

  // Pin sync levels
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_r <= 7'h00;
    end else begin
      pin_r <= pin_val[6:0];
    end
  end

  // Soft sync channels and self-test levels
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      soft_chan_r <= 4'h0;
      test_r <= 2'h0;
    end else begin
      soft_chan_r <= soft_val[3:0];
      test_r <= soft_val[ead_pkg::EAD_SOFT_TEST_LSB +: 2];
    end
  end

  // Start and hop are one-shot pulses, never stored
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      soft_start_r <= 1'b0;
      soft_hop_r <= 1'b0;
    end else begin
      soft_start_r <= soft_wr & host_wdata[ead_pkg::EAD_SOFT_START_BIT];
      soft_hop_r <= soft_wr & host_wdata[ead_pkg::EAD_SOFT_HOP_BIT];
    end
  end

  // Outgoing word is the three holding registers as they stand
  assign int_wdata = {data_top_nibble_r, data_mid_byte_r, data_low_byte_r};
  assign int_chan_en = int_chan_en_r;
  assign int_out_page = int_out_page_r;
  assign int_addr = int_addr_r;
  assign int_wr = int_wr_r;
  assign int_rd = int_rd_r;
  assign sleep_chan = sleep_chan_r;
  assign pin_sync_en = pin_r[3:0];
  assign pin_start_en = pin_r[ead_pkg::EAD_PIN_START_BIT];
  assign pin_hop_en = pin_r[ead_pkg::EAD_PIN_HOP_BIT];
  assign pin_first_only = pin_r[ead_pkg::EAD_PIN_FIRST_BIT];
  assign soft_sync_chan = soft_chan_r;
  assign soft_start_pulse = soft_start_r;
  assign soft_hop_pulse = soft_hop_r;
  assign selftest_input_route = test_r[0];
  assign noise_source_select = test_r[1];

  ////////////////////////////////////////////////////////////////////////
  // Host read path, registered, one cycle after the read strobe
  logic [7:0] rd_mux;
  logic [7:0] ptr_view;
  logic [7:0] rd_bus;
  logic rd_drive;
  logic [7:0] host_rdata_r;
  logic host_rdata_oe_r;
  // Broadcast readback would mix several channels, so the pointer reads zero
  assign ptr_view = bcast ? ead_pkg::EAD_RST_BYTE : internal_address_pointer_r;
  // Low byte read returns internal data directly, since it launches the read
  always_comb begin
    case (host_addr)
      ead_pkg::EAD_OFS_DATA_LOW: rd_mux = int_rdata[7:0];
      ead_pkg::EAD_OFS_DATA_MID: rd_mux = data_mid_byte_r;
      ead_pkg::EAD_OFS_DATA_TOP: rd_mux = {4'h0, data_top_nibble_r};
      ead_pkg::EAD_OFS_POINTER: rd_mux = ptr_view;
      ead_pkg::EAD_OFS_ACCESS: rd_mux = access_mode_control_r;
      default: rd_mux = 8'h00;
    endcase
  end
  // Unselected chip keeps off the shared bus; mode reg always answers
  assign rd_drive = rd_hit & (selected | addr_dec[ead_pkg::EAD_OFS_ACCESS]);
  // Idle bus reads as zero so a stale byte never lingers
  assign rd_bus = rd_drive ? rd_mux : 8'h00;

  // Read data register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      host_rdata_r <= ead_pkg::EAD_RST_BYTE;
    end else begin
      host_rdata_r <= rd_bus;
    end
  end

  // Bus drive flag, high for one cycle per answered read
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      host_rdata_oe_r <= 1'b0;
    end else begin
      host_rdata_oe_r <= rd_drive;
    end
  end
  assign host_rdata = host_rdata_r;
  assign host_rdata_oe = host_rdata_oe_r;
endmodule : ead_external_access_decoder
`default_nettype wire

// ==== test/ead_page_model.sv ====
// Internal page model that answers launched reads
`timescale 1ns/1ps
`default_nettype none
module ead_page_model #(
  parameter logic [19:0] RD_WORD = 20'h9c5e3
) (
  output logic [19:0] int_rdata
);
  // Whole word on offer at once; a launched read never waits
  assign int_rdata = RD_WORD;
endmodule : ead_page_model
`default_nettype wire

// ==== test/ead_external_access_decoder_assertions.sv ====
// Checker of host and internal strobe timing
`timescale 1ns/1ps
`default_nettype none
module ead_checker (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic host_cs,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [2:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata,
  input wire logic host_rdata_oe,
  input wire logic [3:0] int_chan_en,
  input wire logic [19:0] int_wdata,
  input wire logic int_wr,
  input wire logic int_rd,
  input wire logic [19:0] int_rdata
);
  // Accepted host cycles; write wins over read
  wire logic wr_go = host_cs && host_wr;
  wire logic rd_go = host_cs && host_rd && !host_wr;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////
  a_wr_launch: assert property (int_wr |-> $past(wr_go && host_addr == 3'h0))
    else $error("stray internal write");
  a_rd_launch: assert property (int_rd |-> $past(rd_go && host_addr == 3'h0))
    else $error("stray internal read");
  a_launch_sel: assert property ((int_wr || int_rd) |-> int_chan_en != 4'h0)
    else $error("launch with no channel");
  a_low_byte: assert property (int_wr |-> int_wdata[7:0] == $past(host_wdata))
    else $error("low byte lost");
  a_rd_return: assert property (int_rd |-> host_rdata_oe && host_rdata == $past(int_rdata[7:0]))
    else $error("read byte wrong");
  a_oe_cause: assert property (host_rdata_oe |-> $past(rd_go))
    else $error("bus driven unasked");
  a_bus_quiet: assert property (!host_rdata_oe |-> host_rdata == 8'h00)
    else $error("data while undriven");
  a_wo_read: assert property (rd_go && host_addr inside {3'h3, 3'h4, 3'h5} |=> host_rdata == 8'h00)
    else $error("write-only readable");
  a_top_clear: assert property (rd_go && host_addr == 3'h2 |=> host_rdata[7:4] == 4'h0)
    else $error("top upper bits set");
  // Main scenarios reached
  c_all: cover property (int_wr && int_chan_en == 4'hf);
  c_one: cover property (int_wr && int_chan_en == 4'h1);
  c_rd: cover property (int_rd);
endmodule : ead_checker
bind ead_external_access_decoder ead_checker i_chk (.core_clk, .rst_b, .host_cs, .host_wr,
  .host_rd, .host_addr, .host_wdata, .host_rdata, .host_rdata_oe, .int_chan_en, .int_wdata,
  .int_wr, .int_rd, .int_rdata);
`default_nettype wire

// ==== test/ead_external_access_decoder_tb_top.sv ====
// Self-checking bench for the external access decoder
`timescale 1ns/1ps
`default_nettype none
module ead_external_access_decoder_tb_top;
  localparam logic [19:0] RD_WORD = 20'h9c5e3;
  logic core_clk = 1'b0, rst_b = 1'b0, host_cs = 1'b0, host_wr = 1'b0, host_rd = 1'b0;
  logic [2:0] host_addr = 3'h0;
  logic [7:0] host_wdata = 8'h00, host_rdata, got, int_addr;
  logic [3:0] device_select_straps = 4'h6, int_chan_en, sleep_chan, pin_sync_en, soft_sync_chan;
  logic host_rdata_oe, int_out_page, int_wr, int_rd, pin_start_en, pin_hop_en, pin_first_only;
  logic soft_start_pulse, soft_hop_pulse, selftest_input_route, noise_source_select, oe;
  logic [19:0] int_wdata, int_rdata;
  int n_errors = 0, cmp_count = 0;
  always #2.5 core_clk = ~core_clk;
  ead_external_access_decoder i_dut (.core_clk, .rst_b, .host_cs, .host_wr, .host_rd,
    .host_addr, .host_wdata, .host_rdata, .host_rdata_oe, .device_select_straps, .int_chan_en,
    .int_out_page, .int_addr, .int_wdata, .int_wr, .int_rd, .int_rdata, .sleep_chan,
    .pin_sync_en, .pin_start_en, .pin_hop_en, .pin_first_only, .soft_sync_chan,
    .soft_start_pulse, .soft_hop_pulse, .selftest_input_route, .noise_source_select);
  ead_page_model #(.RD_WORD(RD_WORD)) i_page (.int_rdata);
  ////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [19:0] seen, input logic [19:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // Host write; one idle cycle between accesses
  task automatic hw(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    host_cs <= 1'b1;
    host_wr <= 1'b1;
    host_addr <= a;
    host_wdata <= d;
    @(posedge core_clk);
    host_cs <= 1'b0;
    host_wr <= 1'b0;
    #1;
  endtask : hw
  // Host read; answer lands one cycle after the strobe
  task automatic hr(input logic [2:0] a);
    @(posedge core_clk);
    host_cs <= 1'b1;
    host_rd <= 1'b1;
    host_addr <= a;
    @(posedge core_clk);
    host_cs <= 1'b0;
    host_rd <= 1'b0;
    #1;
    got = host_rdata;
    oe = host_rdata_oe;
  endtask : hr
  // Let one more edge pass so the stored control levels show
  task automatic settle();
    @(posedge core_clk);
    #1;
  endtask : settle
  // Strap match, channel 2, auto-increment on
  task automatic t_match();
    hw(3'h7, 8'h9a);
    hw(3'h6, 8'h40);
    hw(3'h2, 8'hf3);
    hw(3'h1, 8'h21);
    hw(3'h0, 8'h87);
    chk("launch", {int_wr, int_chan_en, int_addr}, {1'b1, 4'h4, 8'h40});
    chk("word", int_wdata, 20'h32187);
    hr(3'h6);
    chk("pointer", got, 8'h41);
    hr(3'h7);
    chk("access", got, 8'h9a);
    hw(3'h6, 8'hfe);
    hr(3'h0);
    chk("rd launch", {int_rd, oe, got}, {2'b11, RD_WORD[7:0]});
    hr(3'h1);
    chk("mid", got, RD_WORD[15:8]);
    hr(3'h2);
    chk("top", got, {4'h0, RD_WORD[19:16]});
    hr(3'h6);
    chk("ptr step", got, 8'hff);
  endtask : t_match
  // Every broadcast code, address bits pick channel 1
  task automatic t_bcast();
    logic [3:0] code [11] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h9, 4'hc, 4'hd, 4'he, 4'hf, 4'h3};
    logic [3:0] mask [11] = '{4'hf, 4'h7, 4'he, 4'h2, 4'h2, 4'h0, 4'h0, 4'h0, 4'h2, 4'h0, 4'h0};
    for (int i = 0; i < 11; i++) begin
      hw(3'h7, {2'b01, code[i], 2'b01});
      hw(3'h0, 8'h5a);
      chk("bcast", {int_wr, int_chan_en}, {mask[i] != 4'h0, mask[i]});
    end
    hw(3'h7, 8'h40);
    hr(3'h6);
    chk("bcast ptr", {oe, got}, 9'h100);
  endtask : t_bcast
  // Refused access, write-only controls, output page
  task automatic t_ctrl();
    hw(3'h7, 8'h0c);
    hw(3'h0, 8'h11);
    chk("refused", int_wr, 1'b0);
    hr(3'h1);
    chk("undriven", oe, 1'b0);
    hw(3'h7, 8'h18);
    hw(3'h3, 8'h2f);
    settle();
    chk("sleep", {int_out_page, sleep_chan}, 5'h1f);
    hw(3'h0, 8'h33);
    chk("out page", {int_wr, int_out_page, int_chan_en}, 6'h31);
    hw(3'h5, 8'hd5);
    chk("pulse", {soft_hop_pulse, soft_start_pulse}, 2'h1);
    settle();
    chk("soft", {noise_source_select, selftest_input_route, soft_hop_pulse, soft_start_pulse,
      soft_sync_chan}, 8'hc5);
    hw(3'h4, 8'h5a);
    settle();
    chk("pin", {pin_first_only, pin_hop_en, pin_start_en, pin_sync_en}, 7'h5a);
    hr(3'h5);
    chk("wo read", {oe, got}, 9'h100);
  endtask : t_ctrl
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    t_match();
    t_bcast();
    t_ctrl();
    final_report();
  end
  // Watchdog: the run needs well under a microsecond
  initial begin
    #20000;
    n_errors++;
    final_report();
  end
endmodule : ead_external_access_decoder_tb_top
`default_nettype wire
